// ---- design/dcc_pkg.sv ----
package dcc_pkg;
  localparam int          DCC_AW            = 3;
  localparam logic [2:0]  DCC_CTL0_ADDR     = 3'h0;
  localparam logic [2:0]  DCC_MODE0_ADDR    = 3'h1;
  localparam logic [2:0]  DCC_CTL1_ADDR     = 3'h2;
  localparam logic [2:0]  DCC_MODE1_ADDR    = 3'h3;
  localparam logic [2:0]  DCC_MISC_ADDR     = 3'h4;
  localparam int          DCC_CTL_EN_BIT    = 7;
  localparam int          DCC_CTL_OUT_BIT   = 6;
  localparam int          DCC_CTL_RISE_BIT  = 5;
  localparam int          DCC_CTL_FALL_BIT  = 4;
  localparam int          DCC_MODE_RIE_BIT  = 5;
  localparam int          DCC_MODE_FIE_BIT  = 4;
  localparam int          DCC_MISC_RST_BIT  = 0;
  localparam int          DCC_MISC_PP0_BIT  = 1;
  localparam int          DCC_MISC_PP1_BIT  = 2;
  localparam logic [7:0]  DCC_CTL_RESET     = 8'h00;
  localparam logic [1:0]  DCC_MODE_RESET    = 2'h2;
  localparam logic [1:0]  DCC_HYST_OFF      = 2'h0;
endpackage

// ---- design/dcc_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module dcc_sync
  import dcc_pkg::*;
#(
  parameter int STAGES = 2
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // level
  input  wire logic async_i,
  output logic      sync_o
);
  logic [STAGES-1:0] sh_reg;

  // refuse a chain too short to settle metastability
  if (STAGES < 2) begin : gen_bad_stages
    $error("dcc_sync needs two stages");
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sh_reg <= '0;
    end else begin
      sh_reg <= {sh_reg[STAGES-2:0], async_i};
    end
  end

  assign sync_o = sh_reg[STAGES-1];
endmodule
`default_nettype wire

// ---- design/dcc_channel.sv ----
`timescale 1ns/1ns
`default_nettype none
module dcc_channel
  import dcc_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // comparator
  input  wire logic cmp_sync_i,
  input  wire logic enable_i,
  // flag clear strobes
  input  wire logic clr_rise_i,
  input  wire logic clr_fall_i,
  // flags
  output logic      state_o,
  output logic      rise_flag_o,
  output logic      fall_flag_o
);
  logic prev_reg;
  logic rise_reg;
  logic fall_reg;
  wire  rise_ev;
  wire  fall_ev;

  assign rise_ev = cmp_sync_i & ~prev_reg;
  assign fall_ev = ~cmp_sync_i & prev_reg;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      prev_reg <= cmp_sync_i;
      // set beats clear in the same cycle
      rise_reg <= rise_ev | (rise_reg & ~clr_rise_i);
      fall_reg <= fall_ev | (fall_reg & ~clr_fall_i);
    end
  end

  assign state_o     = prev_reg;
  assign rise_flag_o = rise_reg;
  assign fall_flag_o = fall_reg;

  AST_RISE_SETS: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    rise_ev |=> rise_reg) else $error("rise flag not set");
  AST_FALL_SETS: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    fall_ev |=> fall_reg) else $error("fall flag not set");
  AST_FLAG_STICKY: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (rise_reg && !clr_rise_i) |=> rise_reg) else $error("rise flag lost");
  AST_ONE_EDGE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    rise_ev |=> !rise_ev) else $error("edge seen twice");
endmodule
`default_nettype wire

// ---- design/dcc_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module dcc_top
  import dcc_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  // register port
  input  wire logic [DCC_AW-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  // analog comparator cores
  input  wire logic [1:0]        cmp_raw_i,
  output logic      [1:0]        cmp_power_o,
  output logic      [1:0]        cmp_resp_mode_o [2],
  output logic      [1:0]        cmp_pos_hyst_o [2],
  output logic      [1:0]        cmp_neg_hyst_o [2],
  // crossbar pins
  output logic      [1:0]        pin_out_o,
  output logic      [1:0]        pin_oe_o,
  // system
  output logic      [1:0]        irq_o,
  output logic                   reset_req_o
);
  logic [1:0] en_reg;
  logic [1:0] hyp_reg [2];
  logic [1:0] hyn_reg [2];
  logic [1:0] md_reg [2];
  logic [1:0] rie_reg;
  logic [1:0] fie_reg;
  logic       rst_src_reg;
  logic [1:0] pp_reg;
  logic [7:0] rdata_reg;
  logic [1:0] irq_reg;
  logic       reset_req_reg;
  logic [1:0] pin_out_reg;
  logic [1:0] pin_oe_reg;
  logic [1:0] cmp_sync;
  logic [1:0] state;
  logic [1:0] rise_flag;
  logic [1:0] fall_flag;
  wire  [1:0] wr_ctl;
  wire  [1:0] wr_mode;
  wire  [1:0] clr_rise;
  wire  [1:0] clr_fall;
  wire  [1:0] irq_next;
  wire  [1:0] pin_out_next;
  wire  [1:0] pin_oe_next;
  wire        reset_req_next;
  wire        wr_misc;
  logic [7:0] rdata_next;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_ch
      wire [DCC_AW-1:0] ca = (g == 0) ? DCC_CTL0_ADDR : DCC_CTL1_ADDR;
      wire [DCC_AW-1:0] ma = (g == 0) ? DCC_MODE0_ADDR : DCC_MODE1_ADDR;
      assign wr_ctl[g]   = wr_i && (addr_i == ca);
      assign wr_mode[g]  = wr_i && (addr_i == ma);
      assign clr_rise[g] = wr_ctl[g] && !wdata_i[DCC_CTL_RISE_BIT];
      assign clr_fall[g] = wr_ctl[g] && !wdata_i[DCC_CTL_FALL_BIT];
      // flags only raise irq while comparator is on
      assign irq_next[g] = en_reg[g] &&
        ((rise_flag[g] && rie_reg[g]) || (fall_flag[g] && fie_reg[g]));
      // disabled comparator drives low
      assign pin_out_next[g] = pp_reg[g] ? (en_reg[g] & state[g]) : 1'b0;
      assign pin_oe_next[g]  = pp_reg[g] ? 1'b1 : ~(en_reg[g] & state[g]);

      dcc_sync #(
        .STAGES (2)
      ) u_sync (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .async_i   (cmp_raw_i[g]),
        .sync_o    (cmp_sync[g])
      );

      dcc_channel u_ch (
        .sys_clk_i   (sys_clk_i),
        .nrst_i      (nrst_i),
        .cmp_sync_i  (cmp_sync[g]),
        .enable_i    (en_reg[g]),
        .clr_rise_i  (clr_rise[g]),
        .clr_fall_i  (clr_fall[g]),
        .state_o     (state[g]),
        .rise_flag_o (rise_flag[g]),
        .fall_flag_o (fall_flag[g])
      );

      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          en_reg[g]  <= DCC_CTL_RESET[DCC_CTL_EN_BIT];
          hyp_reg[g] <= DCC_HYST_OFF;
          hyn_reg[g] <= DCC_HYST_OFF;
        end else if (wr_ctl[g]) begin
          en_reg[g]  <= wdata_i[DCC_CTL_EN_BIT];
          hyp_reg[g] <= wdata_i[3:2];
          hyn_reg[g] <= wdata_i[1:0];
        end
      end

      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          md_reg[g]  <= DCC_MODE_RESET;
          rie_reg[g] <= 1'b0;
          fie_reg[g] <= 1'b0;
        end else if (wr_mode[g]) begin
          md_reg[g]  <= wdata_i[1:0];
          rie_reg[g] <= wdata_i[DCC_MODE_RIE_BIT];
          fie_reg[g] <= wdata_i[DCC_MODE_FIE_BIT];
        end
      end

      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cmp_resp_mode_o[g] <= DCC_MODE_RESET;
          cmp_pos_hyst_o[g]  <= DCC_HYST_OFF;
          cmp_neg_hyst_o[g]  <= DCC_HYST_OFF;
        end else begin
          cmp_resp_mode_o[g] <= md_reg[g];
          cmp_pos_hyst_o[g]  <= hyp_reg[g];
          cmp_neg_hyst_o[g]  <= hyn_reg[g];
        end
      end
    end
  endgenerate

  assign wr_misc = wr_i && (addr_i == DCC_MISC_ADDR);
  // only comparator 0 can request a reset
  assign reset_req_next = rst_src_reg && en_reg[0] && (rise_flag[0] | fall_flag[0]);

  always_comb begin
    rdata_next = 8'h00;
    case (addr_i)
      DCC_CTL0_ADDR: rdata_next = {en_reg[0], state[0], rise_flag[0], fall_flag[0],
                                   hyp_reg[0], hyn_reg[0]};
      DCC_CTL1_ADDR: rdata_next = {en_reg[1], state[1], rise_flag[1], fall_flag[1],
                                   hyp_reg[1], hyn_reg[1]};
      DCC_MODE0_ADDR: rdata_next = {2'h0, rie_reg[0], fie_reg[0], 2'h0, md_reg[0]};
      DCC_MODE1_ADDR: rdata_next = {2'h0, rie_reg[1], fie_reg[1], 2'h0, md_reg[1]};
      DCC_MISC_ADDR: rdata_next = {5'h00, pp_reg, rst_src_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_src_reg <= 1'b0;
      pp_reg      <= 2'h0;
    end else if (wr_misc) begin
      rst_src_reg <= wdata_i[DCC_MISC_RST_BIT];
      pp_reg      <= {wdata_i[DCC_MISC_PP1_BIT], wdata_i[DCC_MISC_PP0_BIT]};
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg     <= 8'h00;
      irq_reg       <= 2'h0;
      reset_req_reg <= 1'b0;
      pin_out_reg   <= 2'h0;
      pin_oe_reg    <= 2'h3;
    end else begin
      rdata_reg     <= rd_i ? rdata_next : 8'h00;
      irq_reg       <= irq_next;
      reset_req_reg <= reset_req_next;
      pin_out_reg   <= pin_out_next;
      pin_oe_reg    <= pin_oe_next;
    end
  end

  assign rdata_o     = rdata_reg;
  assign irq_o       = irq_reg;
  assign reset_req_o = reset_req_reg;
  assign pin_out_o   = pin_out_reg;
  assign pin_oe_o    = pin_oe_reg;
  assign cmp_power_o = en_reg;

  AST_IRQ_CAUSE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    irq_o[0] |-> $past(en_reg[0] && ((rise_flag[0] && rie_reg[0]) ||
      (fall_flag[0] && fie_reg[0])))) else $error("irq0 without cause");
  AST_IRQ_DISABLED: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !en_reg[1] |=> !irq_o[1]) else $error("irq1 while disabled");
  AST_PIN_LOW_OFF: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !en_reg[0] |=> !pin_out_o[0]) else $error("pin0 high while disabled");
  AST_ENABLE_WRITE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    wr_ctl[0] |=> cmp_power_o[0] == $past(wdata_i[DCC_CTL_EN_BIT]))
    else $error("enable write lost");
  AST_MODE_WRITE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    wr_mode[1] |=> ##1 cmp_resp_mode_o[1] == $past(wdata_i[1:0], 2))
    else $error("mode not applied");
  AST_RESET_SRC: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    reset_req_o |-> $past(rst_src_reg && en_reg[0])) else $error("bad reset req");
  AST_STATE_READ: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == DCC_CTL0_ADDR) |=> rdata_o[DCC_CTL_OUT_BIT] == $past(state[0]))
    else $error("state readback wrong");
  AST_HYST_FIELD: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    wr_ctl[1] |=> ##1 cmp_pos_hyst_o[1] == $past(wdata_i[3:2], 2))
    else $error("hysteresis not applied");

  COV_IRQ0: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) irq_o[0]);
  COV_IRQ1: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) irq_o[1]);
  COV_RESET: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) reset_req_o);
  COV_BOTH_FLAGS: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
    rise_flag[0] && fall_flag[0]);
endmodule
`default_nettype wire

// ---- verif/dcc_sys_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module dcc_sys_model (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  // requests from the block
  input  wire logic [1:0] irq_i,
  input  wire logic       reset_req_i,
  // request onsets taken
  output logic      [7:0] irq_cnt_o,
  output logic      [7:0] rst_cnt_o
);
  logic [1:0] irq_prev_reg;
  logic       rst_prev_reg;
  // handler and reset logic act on each new level request
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_prev_reg <= 2'h0;
      rst_prev_reg <= 1'b0;
      irq_cnt_o    <= 8'h00;
      rst_cnt_o    <= 8'h00;
    end else begin
      irq_prev_reg <= irq_i;
      rst_prev_reg <= reset_req_i;
      irq_cnt_o    <= irq_cnt_o + 8'(irq_i[0] & ~irq_prev_reg[0])
                      + 8'(irq_i[1] & ~irq_prev_reg[1]);
      rst_cnt_o    <= rst_cnt_o + 8'(reset_req_i & ~rst_prev_reg);
    end
  end
endmodule
`default_nettype wire

// ---- verif/dcc_top_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module dcc_top_test;
  import dcc_pkg::*;
  logic              sys_clk_i;
  logic              nrst_i;
  logic [DCC_AW-1:0] addr_i;
  logic [7:0]        wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [7:0]        rdata_o;
  logic [1:0]        cmp_raw_i;
  logic [1:0]        cmp_power_o;
  logic [1:0]        cmp_resp_mode_o [2];
  logic [1:0]        cmp_pos_hyst_o [2];
  logic [1:0]        cmp_neg_hyst_o [2];
  logic [1:0]        pin_out_o;
  logic [1:0]        pin_oe_o;
  logic [1:0]        irq_o;
  logic              reset_req_o;
  logic [7:0]        irq_cnt;
  logic [7:0]        rst_cnt;
  logic [7:0]        exp_q [$];
  logic              rd_pend = 1'b0;
  logic [31:0]       seed = 32'hA638D986;
  logic [7:0]        rst_val [6] = '{8'h00, 8'h02, 8'h00, 8'h02, 8'h00, 8'h00};
  logic [2:0]        a;
  logic [3:0]        h;
  int                error_cnt = 0;
  int                comparisons = 0;
  int                cyc = 0;

  dcc_top u_dcc_top (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cmp_raw_i(cmp_raw_i), .cmp_power_o(cmp_power_o), .cmp_resp_mode_o(cmp_resp_mode_o),
    .cmp_pos_hyst_o(cmp_pos_hyst_o), .cmp_neg_hyst_o(cmp_neg_hyst_o),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .irq_o(irq_o), .reset_req_o(reset_req_o));
  dcc_sys_model u_dcc_sys_model (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .irq_i(irq_o),
    .reset_req_i(reset_req_o), .irq_cnt_o(irq_cnt), .rst_cnt_o(rst_cnt));

  always #5 sys_clk_i = ~sys_clk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i  <= ad;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] ad, input logic [7:0] exp);
    @(posedge sys_clk_i);
    addr_i <= ad;
    rd_i   <= 1'b1;
    exp_q.push_back(exp);
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk_i) rd_pend <= rd_i;
  always @(negedge sys_clk_i) begin
    if (rd_pend) begin
      chk(rdata_o, exp_q.pop_front());
    end
  end

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("MISMATCH %0t run did not finish", $time);
      wrap_up();
    end
  end

  initial begin
    sys_clk_i = 1'b0;
    nrst_i    = 1'b0;
    addr_i    = 3'h0;
    wdata_i   = 8'h00;
    wr_i      = 1'b0;
    rd_i      = 1'b0;
    cmp_raw_i = 2'h0;
    repeat (8) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 6; i++) rd(3'(i), rst_val[i]);
    settle(1);
    chk({pin_oe_o, pin_out_o, irq_o, cmp_power_o}, 8'hC0);
    $display("reset test done");
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 4; i++) begin
        seed = lfsr(seed);
        h = {2'(i), seed[1:0]};
        wr(3'(2 * ch), {4'h0, h});
        wr(3'(2 * ch + 1), {seed[7:2], 2'(i)});
        settle(2);
        chk(8'(cmp_resp_mode_o[ch]), 8'(i));
        chk({cmp_pos_hyst_o[ch], cmp_neg_hyst_o[ch]}, {4'h0, h});
        rd(3'(2 * ch), {4'h0, h});
        rd(3'(2 * ch + 1), {2'b00, seed[5:4], 2'b00, 2'(i)});
      end
    end
    $display("config test done");
    wr(DCC_MISC_ADDR, 8'h03);
    for (int ch = 0; ch < 2; ch++) begin
      a = 3'(2 * ch);
      wr(a + 3'd1, 8'h22);
      wr(a, 8'h80);
      settle(2);
      chk(8'(cmp_power_o[ch]), 8'h01);
      @(posedge sys_clk_i);
      cmp_raw_i[ch] <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      rd(a, 8'hE0);
      settle(1);
      chk({irq_o[ch], reset_req_o}, {1'b1, ch == 0});
      chk({pin_oe_o[ch], pin_out_o[ch]}, (ch == 0) ? 8'h03 : 8'h00);
      @(posedge sys_clk_i);
      cmp_raw_i[ch] <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      rd(a, 8'hB0);
      wr(a, 8'h90);
      rd(a, 8'h90);
      settle(2);
      chk(8'(irq_o[ch]), 8'h00);
      wr(a + 3'd1, 8'h12);
      settle(2);
      chk(8'(irq_o[ch]), 8'h01);
      wr(a, 8'h10);
      settle(2);
      chk({irq_o[ch], pin_out_o[ch], cmp_power_o[ch], reset_req_o}, 8'h00);
      $display("edge test ch %0d done", ch);
    end
    settle(3);
    chk(irq_cnt, 8'h04);
    chk(rst_cnt, 8'h01);
    wrap_up();
  end
endmodule
`default_nettype wire
